// File: rtl/psf_status.v
// program status flags register with apb access and core update ports
//
// Summary of operation
// - carry flag, bit 7, is set by a carry out of the alu.
// - bit instructions use the carry flag as one-bit accumulator operand and result.
// - half-carry flag, bit 6, records carry or borrow across the nibble boundary.
// - bit 5 is a user flag, written only by software.
// - overflow flag, bit 2, is carry out of bit 7 xor carry out of bit 6.
// - bit 1 is a second user flag, written only by software.
// - bit 0 always shows odd parity of the accumulator.
`timescale 1ns/1ps
`include "psf_consts.vh"
module psf_status (
	// apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// core alu request
	input wire alu_go,
	input wire [2:0] alu_cmd,
	input wire [7:0] alu_a,
	input wire [7:0] alu_b,
	// core bit instruction request
	input wire bit_go,
	input wire [2:0] bit_op,
	input wire bit_operand,
	// core accumulator write
	input wire acc_we,
	input wire [7:0] acc_wdata,
	// core register index
	input wire [2:0] reg_index,
	// status outputs
	output wire [7:0] status_flags,
	output wire [7:0] alu_result,
	output wire [7:0] acc_value,
	output wire [4:0] reg_addr,
	output wire bit_result
);
	reg [7:0] flags_q;
	reg [7:0] flags_d;
	reg [7:0] acc_q;
	reg [7:0] acc_d;
	reg [7:0] res_q;
	reg [7:0] res_d;
	reg [7:0] sw_a_q;
	reg [7:0] sw_b_q;
	reg [31:0] rdata_q;
	reg [31:0] rdata_d;
	wire apb_wr;
	wire apb_rd;
	wire hit;
	wire sw_go;
	wire [2:0] cmd_eff;
	wire [7:0] a_eff;
	wire [7:0] b_eff;
	wire [7:0] sum;
	wire cy_out;
	wire ac_out;
	wire ov_out;
	wire do_alu;
	// per-register write strobes
	wire wr_flags;
	wire wr_op_a;
	wire wr_op_b;
	wire wr_cmd;
	wire wr_acc;
	wire wr_bank;
	wire alu_carry_in;
	wire alu_subtract;
	wire [1:0] bank_sel;

	function addr_mapped;
		input [11:0] a;
		begin
			addr_mapped = (a == `PSF_OFF_FLAGS) || (a == `PSF_OFF_ALU_A) ||
				(a == `PSF_OFF_ALU_B) || (a == `PSF_OFF_ALU_CMD) ||
				(a == `PSF_OFF_ACC) || (a == `PSF_OFF_BANK);
		end
	endfunction

	function parity8;
		input [7:0] v;
		begin
			parity8 = ^v;
		end
	endfunction

	// only the three arithmetic codes run the adder; spare codes do nothing
	function cmd_valid;
		input [2:0] c;
		begin
			case (c)
				`PSF_CMD_ADD: cmd_valid = 1'b1;
				`PSF_CMD_ADDC: cmd_valid = 1'b1;
				`PSF_CMD_SUBB: cmd_valid = 1'b1;
				default: cmd_valid = 1'b0;
			endcase
		end
	endfunction

	// plain add starts from zero, add with carry and subtract chain the flag
	function carry_select;
		input [2:0] c;
		input cy;
		begin
			case (c)
				`PSF_CMD_ADD: carry_select = 1'b0;
				default: carry_select = cy;
			endcase
		end
	endfunction

	// new carry for a single-bit instruction; the carry is operand and result
	function bit_apply;
		input [2:0] op;
		input cy;
		input opd;
		begin
			case (op)
				`PSF_BOP_SETC: bit_apply = 1'b1;
				`PSF_BOP_CLRC: bit_apply = 1'b0;
				`PSF_BOP_CPLC: bit_apply = ~cy;
				`PSF_BOP_ANL: bit_apply = cy & opd;
				`PSF_BOP_ORL: bit_apply = cy | opd;
				`PSF_BOP_MOVC: bit_apply = opd;
				`PSF_BOP_ANLN: bit_apply = cy & ~opd;
				default: bit_apply = cy;
			endcase
		end
	endfunction

	// read value of one register, zero above the byte
	function [31:0] read_mux;
		input [11:0] a;
		input [7:0] flags;
		input [7:0] op_a;
		input [7:0] op_b;
		input [7:0] res;
		input [7:0] acc;
		begin
			case (a)
				`PSF_OFF_FLAGS: read_mux = {24'h000000, flags};
				`PSF_OFF_ALU_A: read_mux = {24'h000000, op_a};
				`PSF_OFF_ALU_B: read_mux = {24'h000000, op_b};
				`PSF_OFF_ALU_CMD: read_mux = {24'h000000, res};
				`PSF_OFF_ACC: read_mux = {24'h000000, acc};
				`PSF_OFF_BANK: read_mux = {30'h0, flags[`PSF_BIT_RS_HI:`PSF_BIT_RS_LO]};
				default: read_mux = 32'h00000000;
			endcase
		end
	endfunction

	assign apb_wr = psel && penable && pwrite && pstrb[0];
	assign apb_rd = psel && !penable && !pwrite;
	assign hit = addr_mapped(paddr);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = rdata_q;
	// one write strobe per register, each taken at the access-phase edge
	assign wr_flags = apb_wr && (paddr == `PSF_OFF_FLAGS);
	assign wr_op_a = apb_wr && (paddr == `PSF_OFF_ALU_A);
	assign wr_op_b = apb_wr && (paddr == `PSF_OFF_ALU_B);
	assign wr_cmd = apb_wr && (paddr == `PSF_OFF_ALU_CMD);
	assign wr_acc = apb_wr && (paddr == `PSF_OFF_ACC);
	assign wr_bank = apb_wr && (paddr == `PSF_OFF_BANK);
	// software may start an alu step by writing a command
	assign sw_go = wr_cmd;
	// a core request wins over a software command in the same cycle
	assign cmd_eff = alu_go ? alu_cmd : pwdata[2:0];
	assign a_eff = alu_go ? alu_a : sw_a_q;
	assign b_eff = alu_go ? alu_b : sw_b_q;
	assign do_alu = (alu_go || sw_go) && cmd_valid(cmd_eff);
	assign alu_carry_in = carry_select(cmd_eff, flags_q[`PSF_BIT_CY]);
	assign alu_subtract = (cmd_eff == `PSF_CMD_SUBB);
	assign bank_sel = flags_q[`PSF_BIT_RS_HI:`PSF_BIT_RS_LO];

	psf_adder u_adder (
		.op_a(a_eff),
		.op_b(b_eff),
		.carry_in(alu_carry_in),
		.subtract(alu_subtract),
		.result(sum),
		.carry_out(cy_out),
		.half_carry(ac_out),
		.overflow(ov_out)
	);

	psf_bank_map u_bank (
		.bank_sel(bank_sel),
		.reg_index(reg_index),
		.reg_addr(reg_addr)
	);

	always @* begin
		flags_d = flags_q;
		acc_d = acc_q;
		res_d = res_q;
		// software write first; parity bit is read only
		if (wr_flags) begin
			flags_d[7:1] = pwdata[7:1];
		end
		if (wr_bank) begin
			flags_d[`PSF_BIT_RS_HI:`PSF_BIT_RS_LO] = pwdata[1:0];
		end
		// core load and alu result come later so that they win
		// hardware carry, half carry and overflow override a same-cycle write
		if (wr_acc) begin
			acc_d = pwdata[7:0];
		end
		if (acc_we) begin
			acc_d = acc_wdata;
		end
		if (do_alu) begin
			res_d = sum;
			acc_d = sum;
			flags_d[`PSF_BIT_CY] = cy_out;
			flags_d[`PSF_BIT_AC] = ac_out;
			flags_d[`PSF_BIT_OV] = ov_out;
		end else if (bit_go) begin
			flags_d[`PSF_BIT_CY] = bit_apply(bit_op, flags_q[`PSF_BIT_CY], bit_operand);
		end
		flags_d[`PSF_BIT_P] = parity8(acc_d);
	end

	always @* begin
		rdata_d = rdata_q;
		// captured in the setup cycle, held through the access phase
		if (apb_rd) begin
			rdata_d = read_mux(paddr, flags_q, sw_a_q, sw_b_q, res_q, acc_q);
		end
	end

	// status word
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= `PSF_FLAGS_RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	// accumulator copy, kept so that parity can follow it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= `PSF_DATA_RST;
		end else begin
			acc_q <= acc_d;
		end
	end

	// last alu result
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_q <= `PSF_DATA_RST;
		end else begin
			res_q <= res_d;
		end
	end

	// software operand a, only changed by a software write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_a_q <= `PSF_DATA_RST;
		end else if (wr_op_a) begin
			sw_a_q <= pwdata[7:0];
		end
	end

	// software operand b, only changed by a software write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_b_q <= `PSF_DATA_RST;
		end else if (wr_op_b) begin
			sw_b_q <= pwdata[7:0];
		end
	end

	// read data register behind prdata
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= `PSF_RDATA_RST;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign status_flags = flags_q;
	assign alu_result = res_q;
	assign acc_value = acc_q;
	assign bit_result = flags_q[`PSF_BIT_CY];
endmodule // psf_status

// File: rtl/psf_consts.vh
// constants for the program status flags block
`ifndef PSF_CONSTS_VH
`define PSF_CONSTS_VH
`define PSF_ADDR_W 12
`define PSF_OFF_FLAGS 12'h0d0
`define PSF_OFF_ALU_A 12'h0d4
`define PSF_OFF_ALU_B 12'h0d8
`define PSF_OFF_ALU_CMD 12'h0dc
`define PSF_OFF_ACC 12'h0e0
`define PSF_OFF_BANK 12'h0e4
`define PSF_BIT_CY 7
`define PSF_BIT_AC 6
`define PSF_BIT_F0 5
`define PSF_BIT_RS_HI 4
`define PSF_BIT_RS_LO 3
`define PSF_BIT_OV 2
`define PSF_BIT_F1 1
`define PSF_BIT_P 0
`define PSF_FLAGS_RST 8'h00
`define PSF_DATA_RST 8'h00
`define PSF_RDATA_RST 32'h00000000
`define PSF_CMD_NONE 3'h0
`define PSF_CMD_ADD 3'h1
`define PSF_CMD_ADDC 3'h2
`define PSF_CMD_SUBB 3'h3
`define PSF_BOP_NONE 3'h0
`define PSF_BOP_SETC 3'h1
`define PSF_BOP_CLRC 3'h2
`define PSF_BOP_CPLC 3'h3
`define PSF_BOP_ANL 3'h4
`define PSF_BOP_ORL 3'h5
`define PSF_BOP_MOVC 3'h6
`define PSF_BOP_ANLN 3'h7
`endif

// File: rtl/psf_adder.v
// eight-bit adder/subtractor with nibble and bit-six carries
`timescale 1ns/1ps
module psf_adder (
	// operands
	input wire [7:0] op_a,
	input wire [7:0] op_b,
	input wire carry_in,
	input wire subtract,
	// results
	output wire [7:0] result,
	output wire carry_out,
	output wire half_carry,
	output wire overflow
);
	wire [7:0] b_eff;
	wire cin_eff;
	wire [4:0] low_sum;
	wire [3:0] mid_sum;
	wire [1:0] top_sum;
	// subtraction adds the complement; borrows are inverted carries
	assign b_eff = subtract ? ~op_b : op_b;
	assign cin_eff = subtract ? ~carry_in : carry_in;
	assign low_sum = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
	assign mid_sum = {1'b0, op_a[6:4]} + {1'b0, b_eff[6:4]} + {3'h0, low_sum[4]};
	assign top_sum = {1'b0, op_a[7]} + {1'b0, b_eff[7]} + {1'b0, mid_sum[3]};
	assign result = {top_sum[0], mid_sum[2:0], low_sum[3:0]};
	assign carry_out = subtract ? ~top_sum[1] : top_sum[1];
	assign half_carry = subtract ? ~low_sum[4] : low_sum[4];
	// carry from bit 7 differs from carry from bit 6
	assign overflow = top_sum[1] ^ mid_sum[3];
endmodule // psf_adder

// File: rtl/psf_bank_map.v
// working register bank address mapping
`timescale 1ns/1ps
module psf_bank_map (
	// bank and register index
	input wire [1:0] bank_sel,
	input wire [2:0] reg_index,
	// direct address of the register
	output wire [4:0] reg_addr
);
	assign reg_addr = {bank_sel, reg_index};
endmodule // psf_bank_map

// File: dv/psf_status_assertions.sv
// checker on the program status flags ports
`timescale 1ns/1ps
module psf_status_chk (
	// apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire [11:0] paddr,
	// core
	input wire alu_go,
	input wire [2:0] alu_cmd,
	input wire [7:0] alu_a,
	input wire [7:0] alu_b,
	input wire bit_go,
	input wire [2:0] bit_op,
	input wire [2:0] reg_index,
	// status
	input wire [7:0] status_flags,
	input wire [7:0] acc_value,
	input wire [4:0] reg_addr,
	input wire bit_result
);
	wire [8:0] sum = alu_a + alu_b;
	wire [4:0] hsum = alu_a[3:0] + alu_b[3:0];
	wire [7:0] lsum = alu_a[6:0] + alu_b[6:0];
	wire ov = sum[8] ^ lsum[7];
	wire sw = psel && paddr == 12'h0d0;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_add;
		alu_go && alu_cmd == 3'h1;
	endsequence
	AST_CY: assert property (s_add |=> status_flags[7] == $past(sum[8]))
		else $error("carry");
	AST_AC: assert property (s_add |=> status_flags[6] == $past(hsum[4]))
		else $error("half carry");
	AST_OV: assert property (s_add |=> status_flags[2] == $past(ov))
		else $error("overflow");
	AST_SETC: assert property (bit_go && bit_op == 3'h1 && !alu_go |=> bit_result)
		else $error("set carry");
	AST_F0: assert property (!sw |=> $stable(status_flags[5]))
		else $error("user flag zero");
	AST_F1: assert property (!sw |=> $stable(status_flags[1]))
		else $error("user flag one");
	AST_PAR: assert property (status_flags[0] == ^acc_value)
		else $error("parity");
	AST_MAP: assert property (reg_addr == {status_flags[4:3], reg_index})
		else $error("bank map");
endmodule // psf_status_chk
bind psf_status psf_status_chk chk_inst (.pclk, .presetn, .psel, .paddr, .alu_go, .alu_cmd,
	.alu_a, .alu_b, .bit_go, .bit_op, .reg_index, .status_flags, .acc_value, .reg_addr,
	.bit_result);

// File: dv/psf_core_model.sv
// cpu core model issuing alu, bit and accumulator requests
`timescale 1ns/1ps
module psf_core_model (
	// clock
	input wire pclk,
	// requests
	output reg alu_go,
	output reg [2:0] alu_cmd,
	output reg [7:0] alu_a,
	output reg [7:0] alu_b,
	output reg bit_go,
	output reg [2:0] bit_op,
	output reg bit_operand,
	output reg acc_we,
	output reg [7:0] acc_wdata
);
	initial {alu_go, alu_cmd, alu_a, alu_b, bit_go, bit_op, bit_operand, acc_we, acc_wdata} = '0;
	// k: 1 alu, 2 bit, 3 accumulator; operands inverted once released
	task go(input [1:0] k, input [2:0] c, input [7:0] a, input [7:0] b);
		@(posedge pclk);
		{alu_go, bit_go, acc_we} <= {k == 2'h1, k == 2'h2, k == 2'h3};
		{alu_cmd, bit_op, alu_a, alu_b, acc_wdata, bit_operand} <= {c, c, a, b, a, a[0]};
		@(posedge pclk);
		{alu_go, bit_go, acc_we} <= 3'h0;
		{alu_a, alu_b, acc_wdata, bit_operand} <= {~a, ~b, ~a, ~a[0]};
	endtask
endmodule // psf_core_model

// File: dv/tb_psf_status.sv
// testbench of the program status flags block
`timescale 1ns/1ps
module tb_psf_status;
	reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
	reg [11:0] paddr = 12'h0;
	reg [31:0] pwdata = 32'h0, r;
	reg [8:0] s;
	reg [7:0] a, b, l;
	reg [4:0] h;
	reg [2:0] ri = 3'h5;
	wire [31:0] prdata;
	wire pready, pslverr, alu_go, bit_go, bit_operand, acc_we, bit_result;
	wire [2:0] alu_cmd, bit_op;
	wire [7:0] alu_a, alu_b, acc_wdata, status_flags, alu_result, acc_value;
	wire [4:0] reg_addr;
	integer miscompares = 0, checked = 0, i;
	always #4 pclk = ~pclk;
	psf_core_model psf_core_model_inst (.pclk, .alu_go, .alu_cmd, .alu_a, .alu_b, .bit_go,
		.bit_op, .bit_operand, .acc_we, .acc_wdata);
	psf_status psf_status_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'h1), .prdata, .pready, .pslverr, .alu_go, .alu_cmd, .alu_a, .alu_b, .bit_go,
		.bit_op, .bit_operand, .acc_we, .acc_wdata, .reg_index(ri), .status_flags,
		.alu_result, .acc_value, .reg_addr, .bit_result);
	task chk(input string n, input [31:0] seen, input [31:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task apb(input w, input [11:0] ad, input [7:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, 24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		{r, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	task test_done;
		if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		miscompares = miscompares + 1;
		test_done;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h0d0, 8'h0);
		chk("flags_reset", r, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			apb(1'b1, 12'h0d0, 8'h23 | (i << 3));
			ri <= 3'h7 - i[2:0];
			#1;
			chk("bank_addr", reg_addr, i * 8 + 7 - i);
		end
		chk("sw_flags", status_flags, 8'h3a);
		for (i = 0; i < 4; i = i + 1) begin
			{a, b} = 64'h4040_0f01_7f81_8080 >> (16 * i);
			{s, h, l} = {a + 9'h0 + b, a[3:0] + 5'h0 + b[3:0], a[6:0] + 8'h0 + b[6:0]};
			psf_core_model_inst.go(2'h1, 3'h1, a, b);
			#1;
			chk("add_res", alu_result, s[7:0]);
			chk("add_flags", {status_flags[7:5], status_flags[2:0]},
				{s[8], h[4], 1'b1, s[8] ^ l[7], 1'b1, ^s[7:0]});
		end
		psf_core_model_inst.go(2'h1, 3'h3, 8'h10, 8'h01);
		#1;
		chk("subb", {alu_result, status_flags[7:6], status_flags[2]}, {8'h0f, 3'b010});
		for (i = 0; i < 8; i = i + 1) begin
			psf_core_model_inst.go(2'h2, 24'hfac688 >> (3 * i), 8'h10 >> i, 8'h0);
			#1;
			chk("bit_carry", bit_result, 8'h5c >> (7 - i) & 1);
		end
		psf_core_model_inst.go(2'h2, 3'h1, 8'h00, 8'h00);
		psf_core_model_inst.go(2'h1, 3'h2, 8'h01, 8'h01);
		#1;
		chk("addc", alu_result, 8'h03);
		psf_core_model_inst.go(2'h3, 3'h0, 8'h07, 8'h0);
		#1;
		chk("parity", {acc_value, status_flags[0]}, {8'h07, 1'b1});
		apb(1'b1, 12'h0e0, 8'h03);
		#1;
		chk("acc_wr", {acc_value, status_flags[0]}, {8'h03, 1'b0});
		apb(1'b1, 12'h0d4, 8'h0f);
		apb(1'b1, 12'h0d8, 8'h01);
		apb(1'b1, 12'h0dc, 8'h01);
		apb(1'b0, 12'h0dc, 8'h0);
		chk("sw_alu", r, 32'h10);
		apb(1'b0, 12'h0d0, 8'h0);
		chk("sw_flags_rd", r, 32'h7b);
		apb(1'b1, 12'h0e4, 8'h01);
		#1;
		chk("bank_alias", reg_addr, 32'd12);
		apb(1'b0, 12'h0e4, 8'h0);
		chk("bank_rd", r, 32'h1);
		apb(1'b0, 12'h0f0, 8'h0);
		chk("unmapped_err", {31'h0, e}, 32'h1);
		chk("unmapped_rd", r, 32'h0);
		test_done;
	end
endmodule // tb_psf_status
